// >>> rtl/display_host_regs.svh
// Constants for the display host port: strap codes, serial framing positions.
// Included by the port's design files; holds definitions only.
`ifndef DISPLAY_HOST_REGS_SVH
`define DISPLAY_HOST_REGS_SVH
// Strap codes are written as {bus_type_strap_b, bus_type_strap_a}.
`define STRAP_6800 2'b10
`define STRAP_8080 2'b11
`define STRAP_SPI 2'b00
`define STRAP_I2C 2'b01
// Target address bits above the selectable low bit.
`define I2C_ADDR_HIGH 6'h1e
`define I2C_CO_BIT 7
`define I2C_DC_BIT 6
`define I2C_ACK_SLOT 4'h8
`define I2C_ACK_END 4'h9
`define SPI_LAST_BIT 3'h7
// Data line that carries the open-drain serial data output.
`define SDA_OUT_MASK 8'h04
`define BUS_ALL_DRIVE 8'hff
`endif

// >>> rtl/display_host_pkg.sv
// Types shared by the display host port and its serial receivers.
// Assumes nothing of its surroundings.
`default_nettype none
package display_host_pkg;
  typedef enum logic [1:0] {
    MODE_6800,
    MODE_8080,
    MODE_SPI,
    MODE_I2C
  } bus_mode_type;

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } byte_xfer_type;
endpackage
`default_nettype wire

// >>> rtl/serial_shift_receiver.sv
// Four-wire serial receiver: eight rising clock edges form one byte.
// Assumes its pins are synchronous to core_clk_i and oversampled by it.
`include "display_host_regs.svh"
`default_nettype none
module serial_shift_receiver
  import display_host_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic chip_sel_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_shift_in_i,
  input wire logic data_cmd_i,
  output logic byte_valid_o,
  output byte_xfer_type byte_o
);
  logic clk_prev_q;
  logic [2:0] count_q;
  logic [6:0] shift_q;
  logic valid_q;
  byte_xfer_type byte_q;

  // Edge decode; a deselected port sees no edges at all.
  wire logic clk_rise = serial_clk_i & ~clk_prev_q & ~chip_sel_n_i;
  wire logic [7:0] shifted = {shift_q, serial_shift_in_i};
  wire logic last_bit = clk_rise & (count_q == `SPI_LAST_BIT);

  assign byte_valid_o = valid_q;
  assign byte_o = byte_q;

  // Most significant bit first; the data/command level is taken with the last bit.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      clk_prev_q <= 1'b1; // A clock idling high must not look like an edge.
      count_q <= '0;
      shift_q <= '0;
      valid_q <= 1'b0;
      byte_q <= '0;
    end else begin
      clk_prev_q <= serial_clk_i;
      valid_q <= last_bit; // RULE13
      if (chip_sel_n_i) begin
        count_q <= '0; // RULE3
      end else if (clk_rise) begin
        count_q <= count_q + 3'h1;
        shift_q <= shifted[6:0]; // RULE13
      end
      if (last_bit) begin
        byte_q <= '{is_data: data_cmd_i, value: shifted}; // RULE5
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_eighth_edge;
    clk_rise && count_q == `SPI_LAST_BIT;
  endsequence
  property p_spi_byte;
    s_eighth_edge |=> byte_valid_o && byte_o.value[0] == $past(serial_shift_in_i)
      && byte_o.is_data == $past(data_cmd_i);
  endproperty
  a_spi_byte: assert property (p_spi_byte) else $error("serial byte not delivered"); // RULE13
endmodule
`default_nettype wire

// >>> rtl/i2c_target_receiver.sv
// Two-wire target receiver: address, control byte, then command or data bytes.
// Assumes synchronous, oversampled clock and data pins; data out is open drain.
`include "display_host_regs.svh"
`default_nettype none
module i2c_target_receiver
  import display_host_pkg::*;
#(
  parameter logic [5:0] ADDR_HIGH = `I2C_ADDR_HIGH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic chip_sel_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic target_addr_lsb_i,
  output logic sda_oe_o,
  output logic byte_valid_o,
  output byte_xfer_type byte_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CTRL, ST_DATA, ST_IGNORE} i2c_state_type;
  i2c_state_type state_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic co_q;
  logic dc_q;
  logic oe_q;
  logic valid_q;
  byte_xfer_type byte_q;

  // Line events.
  wire logic scl_rise = scl_i & ~scl_q;
  wire logic scl_fall = ~scl_i & scl_q;
  wire logic start = scl_i & scl_q & sda_q & ~sda_i;
  wire logic stop = scl_i & scl_q & ~sda_q & sda_i;
  wire logic ack_slot = scl_fall & (cnt_q == `I2C_ACK_SLOT);
  wire logic addr_hit = (sh_q[7:1] == {ADDR_HIGH, target_addr_lsb_i}) & ~sh_q[0]; // RULE6

  assign sda_oe_o = oe_q;
  assign byte_valid_o = valid_q;
  assign byte_o = byte_q;

  // Reads are not offered: a read address is not acknowledged.
  always_ff @(posedge core_clk_i) begin
    if (rst_i || chip_sel_n_i) begin
      state_q <= ST_IDLE; // RULE3
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= '0;
      sh_q <= '0;
      co_q <= 1'b0;
      dc_q <= 1'b0;
      oe_q <= 1'b0;
      valid_q <= 1'b0;
      byte_q <= '0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      valid_q <= 1'b0;
      if (start) begin
        state_q <= ST_ADDR;
        cnt_q <= '0;
        oe_q <= 1'b0;
      end else if (stop) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
        if (scl_rise && cnt_q < `I2C_ACK_SLOT) begin
          sh_q <= {sh_q[6:0], sda_i}; // RULE14
          cnt_q <= cnt_q + 4'h1;
        end else if (ack_slot) begin
          cnt_q <= `I2C_ACK_END;
          case (state_q)
            ST_ADDR: begin
              oe_q <= addr_hit;
              state_q <= addr_hit ? ST_CTRL : ST_IGNORE;
            end
            ST_CTRL: begin
              oe_q <= 1'b1;
              co_q <= sh_q[`I2C_CO_BIT];
              dc_q <= sh_q[`I2C_DC_BIT]; // RULE5
              state_q <= ST_DATA;
            end
            ST_DATA: begin
              oe_q <= 1'b1;
              valid_q <= 1'b1;
              byte_q <= '{is_data: dc_q, value: sh_q};
              state_q <= co_q ? ST_CTRL : ST_DATA;
            end
            default: oe_q <= 1'b0;
          endcase
        end else if (scl_fall && cnt_q == `I2C_ACK_END) begin
          oe_q <= 1'b0;
          cnt_q <= '0;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i || chip_sel_n_i);

  property p_addr_ack;
    (state_q == ST_ADDR && ack_slot && addr_hit) |=> sda_oe_o && state_q == ST_CTRL;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // RULE6

  property p_addr_nack;
    (state_q == ST_ADDR && ack_slot && !addr_hit) |=> !sda_oe_o [*2];
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged"); // RULE14
endmodule
`default_nettype wire

// >>> rtl/display_host_interface.sv
// Host port of a 128x32 display controller: selects one of four host buses
// from two straps and delivers each received byte, marked data or command.
// Assumes all pins are synchronous to core_clk_i; the core answers reads
// on rd_byte_i while a read is open, and the board resolves the bus wires.
//
// Notes on behaviour
// RULE1 - Four host buses: 6800 parallel, 8080 parallel, four-wire serial, I2C.
// RULE2 - Two static straps select the bus; each of four codes one bus.
// RULE3 - Bus operations are answered only while chip select is low.
// RULE4 - Low reset pin initializes the port; the host keeps it high otherwise.
// RULE5 - Data/command high marks a byte as data, low as command.
// RULE6 - In I2C mode data/command is the low selectable target address bit.
// RULE7 - In 6800 mode direction high reads, low writes.
// RULE8 - In 6800 mode a transfer runs while enable is high and chip selected.
// RULE9 - In 8080 mode direction is a low-active write strobe.
// RULE10 - In 8080 mode enable is a low-active read strobe.
// RULE11 - In serial modes the host grounds direction and enable pins.
// RULE12 - Eight-bit two-way data bus, driven by the device only during reads; the code also drives line 2 low for the I2C acknowledge.
// RULE13 - Four-wire serial: line 0 clock, line 1 data in, line 2 open.
// RULE14 - I2C: lines 1 and 2 joined as serial data, line 0 clock.
// RULE15 - Deselected, strobes are ignored and the data bus stays undriven.
`include "display_host_regs.svh"
`default_nettype none
module display_host_interface
  import display_host_pkg::*;
#(
  parameter logic [5:0] I2C_ADDR_HIGH = `I2C_ADDR_HIGH
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic bus_type_strap_a_i,
  input wire logic bus_type_strap_b_i,
  input wire logic chip_sel_n_i,
  input wire logic init_hold_n_i,
  input wire logic data_cmd_i,
  input wire logic rw_i,
  input wire logic enable_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic [7:0] data_oe_o,
  input wire logic [7:0] rd_byte_i,
  output logic xfer_valid_o,
  output byte_xfer_type xfer_o,
  output logic rd_req_o,
  output logic rd_is_data_o,
  output logic init_active_o,
  output bus_mode_type bus_mode_o
);
  // Either reset source clears the whole port; the pin one is the host's.
  wire logic rst_all = rst_i | ~init_hold_n_i; // RULE4

  // Strap decode.
  wire logic [1:0] strap_code = {bus_type_strap_b_i, bus_type_strap_a_i};
  wire bus_mode_type strap_mode =
    (strap_code == `STRAP_6800) ? MODE_6800 :
    (strap_code == `STRAP_8080) ? MODE_8080 :
    (strap_code == `STRAP_SPI) ? MODE_SPI : MODE_I2C; // RULE1

  // Port state; every output of the port is read from one of these.
  bus_mode_type mode_q;
  logic wr_act_q;
  logic rd_act_q;
  byte_xfer_type wr_hold_q;
  logic xfer_valid_q;
  byte_xfer_type xfer_q;
  logic rd_req_q;
  logic rd_is_data_q;
  logic [7:0] data_q;
  logic [7:0] data_oe_q;
  logic init_q;

  // Mode flags come from the latched straps, not the live pins.
  wire logic is_6800 = (mode_q == MODE_6800);
  wire logic is_8080 = (mode_q == MODE_8080);
  wire logic is_spi = (mode_q == MODE_SPI);
  wire logic is_i2c = (mode_q == MODE_I2C);
  wire logic selected = ~chip_sel_n_i; // RULE3

  // Parallel strobe decode. In 6800 mode enable frames the cycle and the
  // direction pin picks read or write; in 8080 mode each pin is its own
  // strobe. A read needs the write strobe idle so the two never overlap.
  wire logic wr_6800 = is_6800 & enable_i & ~rw_i; // RULE7 RULE8
  wire logic rd_6800 = is_6800 & enable_i & rw_i; // RULE7 RULE8
  wire logic wr_8080 = is_8080 & ~rw_i; // RULE9
  wire logic rd_8080 = is_8080 & ~enable_i & rw_i; // RULE10
  wire logic wr_act = selected & (wr_6800 | wr_8080); // RULE15
  wire logic rd_act = selected & (rd_6800 | rd_8080); // RULE15

  // A write byte is taken at the closing edge of its strobe, with the bus
  // value of the last active cycle. Deselecting mid-strobe drops the byte.
  wire logic par_wr_done = wr_act_q & ~wr_act & selected; // RULE3
  wire logic rd_start = rd_act & ~rd_act_q;

  // Serial receivers; each is held in reset unless its mode is strapped.
  logic spi_valid;
  byte_xfer_type spi_byte;
  logic i2c_valid;
  byte_xfer_type i2c_byte;
  logic i2c_sda_oe;

  serial_shift_receiver u_spi (
    .core_clk_i(core_clk_i),
    .rst_i(rst_all | ~is_spi),
    .chip_sel_n_i(chip_sel_n_i),
    .serial_clk_i(data_i[0]),
    .serial_shift_in_i(data_i[1]),
    .data_cmd_i(data_cmd_i),
    .byte_valid_o(spi_valid),
    .byte_o(spi_byte)
  ); // RULE13

  i2c_target_receiver #(
    .ADDR_HIGH(I2C_ADDR_HIGH)
  ) u_i2c (
    .core_clk_i(core_clk_i),
    .rst_i(rst_all | ~is_i2c),
    .chip_sel_n_i(chip_sel_n_i),
    .scl_i(data_i[0]),
    .sda_i(data_i[1]),
    .target_addr_lsb_i(data_cmd_i),
    .sda_oe_o(i2c_sda_oe),
    .byte_valid_o(i2c_valid),
    .byte_o(i2c_byte)
  ); // RULE14 RULE6

  // Byte selection toward the core. Only the strapped path can be active,
  // so the selects are exclusive.
  wire logic xfer_valid_d = par_wr_done | (is_spi & spi_valid) | (is_i2c & i2c_valid);
  wire byte_xfer_type xfer_d =
    par_wr_done ? wr_hold_q :
    is_spi ? spi_byte : i2c_byte;

  // Data bus drive: the whole bus only during a parallel read, otherwise at
  // most the open-drain serial data line, which is always driven low.
  wire logic [7:0] i2c_oe_vec = {8{i2c_sda_oe}} & `SDA_OUT_MASK; // RULE14
  wire logic [7:0] data_oe_d = rd_act ? `BUS_ALL_DRIVE : i2c_oe_vec; // RULE12
  wire logic [7:0] data_d = rd_act ? rd_byte_i : 8'h00;

  // Straight from flops, so the pins never see a decode glitch.
  assign data_o = data_q;
  assign data_oe_o = data_oe_q;
  assign xfer_valid_o = xfer_valid_q;
  assign xfer_o = xfer_q;
  assign rd_req_o = rd_req_q;
  assign rd_is_data_o = rd_is_data_q;
  assign init_active_o = init_q;
  assign bus_mode_o = mode_q;

  // The straps are caught only during reset, so a strap that moves while
  // running cannot switch the bus under a transfer in progress.
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      mode_q <= strap_mode; // RULE2
      init_q <= 1'b1; // RULE4
    end else begin
      init_q <= 1'b0;
    end
  end

  // Parallel strobe tracking.
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      wr_hold_q <= '0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        wr_hold_q <= '{is_data: data_cmd_i, value: data_i}; // RULE5
      end
    end
  end

  // Registered outputs toward the core and the pins.
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      xfer_valid_q <= 1'b0;
      xfer_q <= '0;
      rd_req_q <= 1'b0;
      rd_is_data_q <= 1'b0;
      data_q <= 8'h00;
      data_oe_q <= 8'h00;
    end else begin
      xfer_valid_q <= xfer_valid_d;
      if (xfer_valid_d) begin
        xfer_q <= xfer_d;
      end
      rd_req_q <= rd_start; // RULE7 RULE10
      if (rd_start) begin
        rd_is_data_q <= data_cmd_i; // RULE5
      end
      data_q <= data_d;
      data_oe_q <= data_oe_d; // RULE12 RULE15
    end
  end

  // Checks on the port's behaviour.
  // The pin reset disables all of them except a_init_hold, which only the core reset disables.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_all);

  property p_init_hold;
    disable iff (rst_i)
    !init_hold_n_i |=> init_active_o && !xfer_valid_o && data_oe_o == 8'h00;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("port active during init"); // RULE4

  property p_strap_static;
    $changed(strap_code) |=> bus_mode_o == $past(bus_mode_o);
  endproperty
  a_strap_static: assert property (p_strap_static) else $error("bus mode moved"); // RULE2

  property p_deselect_quiet;
    chip_sel_n_i && $past(chip_sel_n_i) |=> !xfer_valid_o && data_oe_o == 8'h00;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("deselected port active"); // RULE15

  property p_deselect_no_read;
    chip_sel_n_i |=> !rd_req_o;
  endproperty
  a_deselect_no_read: assert property (p_deselect_no_read) else $error("read while deselected"); // RULE3

  sequence s_6800_write;
    (is_6800 && selected && enable_i && !rw_i) ##1 (selected && !enable_i);
  endsequence
  property p_6800_write;
    s_6800_write |=> xfer_valid_o && xfer_o.value == $past(data_i, 2)
      && xfer_o.is_data == $past(data_cmd_i, 2);
  endproperty
  a_6800_write: assert property (p_6800_write) else $error("6800 write lost"); // RULE8

  sequence s_8080_write;
    (is_8080 && selected && !rw_i) ##1 (selected && rw_i);
  endsequence
  property p_8080_write;
    s_8080_write |=> xfer_valid_o && xfer_o.value == $past(data_i, 2)
      && xfer_o.is_data == $past(data_cmd_i, 2);
  endproperty
  a_8080_write: assert property (p_8080_write) else $error("8080 write lost"); // RULE9

  sequence s_6800_read_open;
    is_6800 && selected && enable_i && rw_i && !rd_act_q;
  endsequence
  property p_6800_read;
    s_6800_read_open |=> rd_req_o && data_oe_o == `BUS_ALL_DRIVE && !xfer_valid_o;
  endproperty
  a_6800_read: assert property (p_6800_read) else $error("6800 read not served"); // RULE7

  sequence s_8080_read_open;
    is_8080 && selected && !enable_i && rw_i && !rd_act_q;
  endsequence
  property p_8080_read;
    s_8080_read_open |=> rd_req_o && data_oe_o == `BUS_ALL_DRIVE;
  endproperty
  a_8080_read: assert property (p_8080_read) else $error("8080 read not served"); // RULE10

  property p_serial_no_drive;
    (is_spi || is_i2c) |=> (data_oe_o & ~`SDA_OUT_MASK) == 8'h00 && !rd_req_o;
  endproperty
  a_serial_no_drive: assert property (p_serial_no_drive) else $error("bus driven in serial"); // RULE12

  property p_drive_only_low;
    data_oe_o != 8'h00 && !is_6800 && !is_8080 |-> data_o == 8'h00;
  endproperty
  a_drive_only_low: assert property (p_drive_only_low) else $error("serial data driven high"); // RULE14

  // A read hands the bus back one cycle after its strobe ends.
  sequence s_read_end;
    rd_act_q && !rd_act;
  endsequence
  property p_read_release;
    s_read_end |=> data_oe_o == 8'h00;
  endproperty
  a_read_release: assert property (p_read_release) else $error("bus kept"); // RULE12

  // Read data trails the core's byte by one cycle.
  property p_read_data;
    rd_act |=> data_o == $past(rd_byte_i);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong"); // RULE12

  // One request per read, however long the strobe is held.
  property p_read_pulse;
    rd_req_o |=> !rd_req_o;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read asked twice"); // RULE7

  // The acknowledge pulls only the joined data line, and only low;
  // driving it high would fight the pull-up.
  property p_ack_drive;
    is_i2c && i2c_sda_oe |=> data_oe_o == `SDA_OUT_MASK && data_o == 8'h00;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack drive wrong"); // RULE14

  // A serial byte reaches the core unchanged, one cycle later.
  property p_serial_pass;
    is_spi && spi_valid |=> xfer_valid_o && xfer_o == $past(spi_byte);
  endproperty
  a_serial_pass: assert property (p_serial_pass) else $error("serial byte lost"); // RULE13
endmodule
`default_nettype wire

// >>> verif/host_bus_model.sv
// Host side model: drives the display port pins in every bus mode.
// Assumes the bench resolves the shared data lines and feeds them back on bus_i.
`default_nettype none
module host_bus_model (
  input wire logic core_clk_i,
  input wire logic [7:0] bus_i,
  output logic chip_sel_n_o,
  output logic data_cmd_o,
  output logic rw_o,
  output logic enable_o,
  output logic [7:0] bus_o,
  output logic [7:0] bus_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins start deselected with the bus released.
  initial begin
    chip_sel_n_o = 1'b1;
    data_cmd_o = 1'b0;
    rw_o = 1'b0;
    enable_o = 1'b0;
    bus_o = 8'h00;
    bus_oe_o = 8'h00;
  end

  // Every change lands just after a falling edge, half a cycle clear of sampling.
  task automatic w(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Strobes at rest; serial modes keep both strobe pins grounded.
  task automatic rest(input logic i80, input logic ser);
    rw_o = i80 & ~ser;
    enable_o = i80 & ~ser;
  endtask

  // One write: strobe active a cycle, inactive a cycle with select still low.
  task automatic pwrite(input logic i80, input logic cs_n, input logic dc, input logic [7:0] v);
    chip_sel_n_o = cs_n;
    data_cmd_o = dc;
    bus_o = v;
    bus_oe_o = 8'hff;
    if (i80) begin
      rw_o = 1'b0;
    end else begin
      enable_o = 1'b1;
    end
    w(1);
    rest(i80, 1'b0);
    w(1);
    bus_oe_o = 8'h00;
    chip_sel_n_o = 1'b1;
    w(1);
  endtask

  // One read held two cycles; the bus is sampled after the one-cycle data lag.
  task automatic pread(input logic i80, input logic cs_n, input logic dc, output logic [7:0] v);
    chip_sel_n_o = cs_n;
    data_cmd_o = dc;
    bus_oe_o = 8'h00;
    rw_o = 1'b1;
    enable_o = ~i80;
    w(2);
    v = bus_i;
    rest(i80, 1'b0);
    w(1);
    chip_sel_n_o = 1'b1;
    w(1);
  endtask

  // Four-wire serial, MSB first; the clock stands low outside the frame.
  task automatic spi_bits(input logic dc, input logic [7:0] v, input int n);
    chip_sel_n_o = 1'b0;
    data_cmd_o = dc;
    bus_oe_o = 8'h03;
    for (int i = 7; i > 7 - n; i--) begin
      bus_o = {6'h00, v[i], 1'b0};
      w(2);
      bus_o[0] = 1'b1;
      w(2);
    end
    bus_o[0] = 1'b0;
    w(4);
    chip_sel_n_o = 1'b1;
    bus_oe_o = 8'h01;
    w(2);
  endtask

  // Open-drain data: the host only ever pulls line 1 low or lets it go.
  task automatic sda(input logic b);
    bus_o[1] = 1'b0;
    bus_oe_o[1] = ~b;
  endtask

  task automatic scl_pulse(output logic s);
    w(3);
    bus_o[0] = 1'b1;
    w(2);
    s = bus_i[1];
    w(1);
    bus_o[0] = 1'b0;
    w(1);
  endtask

  task automatic i2c_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda(v[i]);
      scl_pulse(s);
    end
    sda(1'b1);
    scl_pulse(s);
    ack = ~s;
  endtask

  // Start, address, control and one data byte, then stop.
  task automatic i2c_write(input logic lsb, input logic [7:0] a, input logic [7:0] c,
                           input logic [7:0] d, output logic [2:0] ack);
    chip_sel_n_o = 1'b0;
    data_cmd_o = lsb;
    bus_o = 8'h01;
    bus_oe_o = 8'h01;
    w(3);
    sda(1'b0);
    w(3);
    bus_o[0] = 1'b0;
    w(1);
    i2c_byte(a, ack[2]);
    i2c_byte(c, ack[1]);
    i2c_byte(d, ack[0]);
    sda(1'b0);
    w(3);
    bus_o[0] = 1'b1;
    w(3);
    sda(1'b1);
    w(3);
    chip_sel_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verif/display_host_interface_tb.sv
// Self-checking bench for the display host port in all four bus modes.
// Assumes the host model drives the pins; undriven data lines float high.
`include "display_host_regs.svh"
`default_nettype none
module display_host_interface_tb
  import display_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap_a = 1'b0;
  logic strap_b = 1'b1;
  logic init_hold_n = 1'b1;
  logic tie = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic cs_n, dc, rw, en, xfer_valid, rd_req, rd_is_data, init_active;
  logic [7:0] hd, hoe, dev_d, dev_oe, wl, data_in;
  byte_xfer_type xfer, last_x;
  bus_mode_type mode;
  int error_cnt = 0;
  int n_compared = 0;
  int xfer_cnt = 0;
  int rd_cnt = 0;
  int cyc = 0;

  // Wired-and of both parties; in the two-wire mode lines 1 and 2 are joined.
  assign wl = (dev_d | ~dev_oe) & (hd | ~hoe);
  assign data_in = {wl[7:3], wl[2] & (wl[1] | ~tie), wl[1] & (wl[2] | ~tie), wl[0]};

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  host_bus_model u_host_bus_model (.core_clk_i(core_clk_i), .bus_i(data_in),
    .chip_sel_n_o(cs_n), .data_cmd_o(dc), .rw_o(rw), .enable_o(en), .bus_o(hd),
    .bus_oe_o(hoe));

  display_host_interface u_display_host_interface (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .bus_type_strap_a_i(strap_a), .bus_type_strap_b_i(strap_b), .chip_sel_n_i(cs_n),
    .init_hold_n_i(init_hold_n), .data_cmd_i(dc), .rw_i(rw), .enable_i(en),
    .data_i(data_in), .data_o(dev_d), .data_oe_o(dev_oe), .rd_byte_i(rd_byte),
    .xfer_valid_o(xfer_valid), .xfer_o(xfer), .rd_req_o(rd_req),
    .rd_is_data_o(rd_is_data), .init_active_o(init_active), .bus_mode_o(mode));

  // Counts pulses so a missing or doubled byte shows; also cuts a hang short.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (xfer_valid === 1'b1) begin
      xfer_cnt <= xfer_cnt + 1;
      last_x <= xfer;
    end
    if (rd_req === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Straps only count while in reset, so every mode change goes through reset.
  task automatic reset_to(input logic [1:0] s);
    bus_mode_type m;
    m = (s == `STRAP_6800) ? MODE_6800 : (s == `STRAP_8080) ? MODE_8080 :
        (s == `STRAP_SPI) ? MODE_SPI : MODE_I2C;
    {strap_b, strap_a} = s;
    tie = (s == `STRAP_I2C);
    u_host_bus_model.rest(s == `STRAP_8080, s[1] == 1'b0);
    rst_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk("init_active in reset", {8'h00, init_active}, 9'h001);
    rst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("init_active after", {8'h00, init_active}, 9'h000);
    chk("bus_mode", {7'h00, mode}, {7'h00, m});
  endtask

  task automatic t_straps();
    for (int i = 0; i < 4; i++) begin
      reset_to(i[1:0]);
    end
  endtask

  // Two writes, a read, then one write and one read with select high.
  task automatic t_parallel(input logic i80);
    int nx;
    int nr;
    logic [7:0] v;
    reset_to(i80 ? `STRAP_8080 : `STRAP_6800);
    nx = xfer_cnt;
    u_host_bus_model.pwrite(i80, 1'b0, 1'b1, 8'h3c);
    repeat (2) @(negedge core_clk_i);
    chk("data byte", last_x, 9'h13c);
    u_host_bus_model.pwrite(i80, 1'b0, 1'b0, 8'ha5);
    repeat (2) @(negedge core_clk_i);
    chk("command byte", last_x, 9'h0a5);
    chk("write count", 9'(xfer_cnt - nx), 9'h002);
    rd_byte = 8'h96;
    nr = rd_cnt;
    u_host_bus_model.pread(i80, 1'b0, 1'b1, v);
    chk("read data", {1'b0, v}, 9'h096);
    chk("read marked data", {8'h00, rd_is_data}, 9'h001);
    repeat (2) @(negedge core_clk_i);
    chk("bus released", {1'b0, dev_oe}, 9'h000);
    chk("read count", 9'(rd_cnt - nr), 9'h001);
    u_host_bus_model.pwrite(i80, 1'b1, 1'b1, 8'h11);
    u_host_bus_model.pread(i80, 1'b1, 1'b1, v);
    repeat (2) @(negedge core_clk_i);
    chk("deselected read bus", {1'b0, v}, 9'h0ff);
    chk("deselected write", 9'(xfer_cnt - nx), 9'h002);
    chk("deselected read", 9'(rd_cnt - nr), 9'h001);
  endtask

  // A partial byte cut by select high is lost; whole bytes then arrive.
  task automatic t_spi();
    int nx;
    reset_to(`STRAP_SPI);
    nx = xfer_cnt;
    u_host_bus_model.spi_bits(1'b1, 8'hf0, 4);
    u_host_bus_model.spi_bits(1'b1, 8'h5a, 8);
    chk("serial data byte", last_x, 9'h15a);
    u_host_bus_model.spi_bits(1'b0, 8'h81, 8);
    chk("serial command byte", last_x, 9'h081);
    chk("serial count", 9'(xfer_cnt - nx), 9'h002);
  endtask

  // Address low bit from the data/command pin decides whether the port answers.
  task automatic t_i2c();
    int nx;
    logic [2:0] ack;
    reset_to(`STRAP_I2C);
    nx = xfer_cnt;
    u_host_bus_model.i2c_write(1'b1, 8'h78, 8'h40, 8'h22, ack);
    chk("foreign address acks", {6'h00, ack}, 9'h000);
    chk("foreign address count", 9'(xfer_cnt - nx), 9'h000);
    u_host_bus_model.i2c_write(1'b1, 8'h7a, 8'h40, 8'h7e, ack);
    chk("own address acks", {6'h00, ack}, 9'h007);
    chk("two-wire data byte", last_x, 9'h17e);
    chk("two-wire count", 9'(xfer_cnt - nx), 9'h001);
    u_host_bus_model.i2c_write(1'b0, 8'h78, 8'h80, 8'hc3, ack);
    chk("low address acks", {6'h00, ack}, 9'h007);
    chk("single command byte", last_x, 9'h0c3);
    chk("two-wire total", 9'(xfer_cnt - nx), 9'h002);
  endtask

  // The reset pin alone reloads the straps and restarts the port.
  task automatic t_init_pin();
    reset_to(`STRAP_6800);
    {strap_b, strap_a} = `STRAP_8080;
    u_host_bus_model.rest(1'b1, 1'b0);
    repeat (2) @(negedge core_clk_i);
    chk("strap moved running", {7'h00, mode}, {7'h00, MODE_6800});
    init_hold_n = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("pin reset active", {8'h00, init_active}, 9'h001);
    init_hold_n = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("pin reset over", {8'h00, init_active}, 9'h000);
    chk("pin reset mode", {7'h00, mode}, {7'h00, MODE_8080});
    u_host_bus_model.pwrite(1'b1, 1'b0, 1'b1, 8'h6d);
    repeat (2) @(negedge core_clk_i);
    chk("write after pin reset", last_x, 9'h16d);
  endtask

  initial begin
    t_straps();
    t_parallel(1'b0);
    t_parallel(1'b1);
    t_spi();
    t_i2c();
    t_init_pin();
    tally_and_finish();
  end
endmodule
`default_nettype wire
